// ==== hw/ufc_top.sv ====
// module: one channel register bank with flow characters, reset states and pins
`timescale 1ns/1ns
module ufc_top (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              bus_sel,
   input  wire logic              bus_rd,
   input  wire logic              bus_wr,
   input  wire ufc_pkg::ufc_addr_t bus_addr,
   input  wire ufc_pkg::ufc_data_t bus_din,
   output wire ufc_pkg::ufc_data_t bus_dout,
   output wire logic              bus_doe,
   input  wire logic              tx_ctrl_sent,
   input  wire logic              tx_ctrl_resume,
   input  wire logic              rx_ctrl_seen,
   input  wire logic              rx_ctrl_resume,
   input  wire logic              rx_char_valid,
   input  wire ufc_pkg::ufc_data_t rx_char,
   input  wire ufc_pkg::ufc_data_t line_status_in,
   input  wire ufc_pkg::ufc_data_t int_source_in,
   input  wire ufc_pkg::ufc_data_t tx_level_in,
   input  wire ufc_pkg::ufc_data_t rx_level_in,
   input  wire ufc_pkg::ufc_nib_t  modem_in,
   input  wire logic              tx_serial_in,
   input  wire logic              ir_pulse_in,
   output wire logic              serial_tx,
   output wire logic              infrared_out,
   output wire logic              rts_n,
   output wire logic              dtr_n,
   output wire logic              thr_load,
   output wire ufc_pkg::ufc_data_t thr_data,
   output wire ufc_pkg::ufc_data_t divisor_low,
   output wire ufc_pkg::ufc_data_t divisor_high_byte,
   output wire ufc_pkg::ufc_data_t divisor_fraction,
   output wire ufc_pkg::ufc_data_t int_enable,
   output wire ufc_pkg::ufc_data_t fifo_ctrl,
   output wire ufc_pkg::ufc_data_t line_ctrl,
   output wire ufc_pkg::ufc_data_t feature_ctrl,
   output wire ufc_pkg::ufc_data_t enhanced_feature,
   output wire ufc_pkg::ufc_data_t tx_trigger,
   output wire ufc_pkg::ufc_data_t rx_trigger,
   output wire ufc_pkg::ufc_data_t resume_char_one,
   output wire ufc_pkg::ufc_data_t resume_char_two,
   output wire ufc_pkg::ufc_data_t pause_char_one,
   output wire ufc_pkg::ufc_data_t pause_char_two,
   output wire logic              sw_flow_off
);
   import ufc_pkg::*;

   // configuration registers
   ufc_data_t div_lo_q;
   ufc_data_t div_hi_q;
   ufc_data_t div_fr_q;
   ufc_data_t ier_q;
   ufc_data_t fcr_q;
   ufc_data_t lcr_q;
   ufc_data_t mcr_q;
   ufc_data_t spr_q;
   ufc_data_t feature_control_reg_q;
   ufc_data_t efr_q;
   ufc_data_t tx_trig_q;
   ufc_data_t rx_trig_q;
   ufc_data_t resume1_q;
   ufc_data_t resume2_q;
   ufc_data_t pause1_q;
   ufc_data_t pause2_q;
   // status registers and holding
   ufc_data_t isr_q;
   ufc_data_t lsr_q;
   ufc_data_t tx_lvl_q;
   ufc_data_t rx_lvl_q;
   ufc_nib_t  msr_delta_q;
   ufc_nib_t  msr_prev_q;
   logic      msr_primed_q;
   ufc_data_t rhr_q;
   ufc_data_t thr_q;
   logic      thr_load_q;
   // pins and bus answer
   logic      serial_tx_q;
   logic      ir_out_q;
   logic      rts_n_q;
   logic      dtr_n_q;
   logic      sw_off_q;
   ufc_data_t dout_q;
   logic      doe_q;
   ufc_data_t rd_mux;
   logic      wr_hit;
   logic      rd_hit;

   ufc_flow_if flow_bus ();

   // bus strobes
   assign wr_hit = bus_sel && bus_wr;
   assign rd_hit = bus_sel && bus_rd && !bus_wr;

   // writable channel registers
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         div_lo_q  <= RST_DIV_LO;
         div_hi_q  <= RST_ZERO;
         div_fr_q  <= RST_ZERO;
         ier_q     <= RST_ZERO;
         fcr_q     <= RST_ZERO;
         lcr_q     <= RST_ZERO;
         mcr_q     <= RST_ZERO;
         spr_q     <= RST_SPR;
         feature_control_reg_q    <= RST_ZERO;
         efr_q     <= RST_ZERO;
         tx_trig_q <= RST_ZERO;
         rx_trig_q <= RST_ZERO;
      end else if (wr_hit) begin
         case (bus_addr)
            OFF_DIV_LO:  div_lo_q  <= bus_din;
            OFF_DIV_HI:  div_hi_q  <= bus_din;
            OFF_DIV_FR:  div_fr_q  <= bus_din;
            OFF_IER:     ier_q     <= bus_din;
            OFF_ISR_FCR: fcr_q     <= bus_din;
            OFF_LCR:     lcr_q     <= bus_din;
            OFF_MCR:     mcr_q     <= bus_din;
            OFF_SPR:     spr_q     <= bus_din;
            OFF_FEATURE_CONTROL_REG:    feature_control_reg_q    <= bus_din;
            OFF_EFR:     efr_q     <= bus_din;
            OFF_TXFIFO:  tx_trig_q <= bus_din;
            OFF_RXFIFO:  rx_trig_q <= bus_din;
            default: begin
            end
         endcase
      end
   end

   // write-only flow control characters
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         resume1_q <= RST_ZERO;
         resume2_q <= RST_ZERO;
         pause1_q  <= RST_ZERO;
         pause2_q  <= RST_ZERO;
      end else if (wr_hit) begin
         case (bus_addr)
            OFF_RESUME1: resume1_q <= bus_din;
            OFF_RESUME2: resume2_q <= bus_din;
            OFF_PAUSE1:  pause1_q  <= bus_din;
            OFF_PAUSE2:  pause2_q  <= bus_din;
            default: begin
            end
         endcase
      end
   end

   // software flow control off when every select bit is clear
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sw_off_q <= 1'b1;
      end else begin
         sw_off_q <= (efr_q[EFR_SWFC_HI:EFR_SWFC_LO] == NIB_ZERO);
      end
   end

   // live status copies from the serial core
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         isr_q    <= RST_ISR;
         lsr_q    <= RST_LSR;
         tx_lvl_q <= RST_ZERO;
         rx_lvl_q <= RST_ZERO;
      end else begin
         isr_q    <= int_source_in;
         lsr_q    <= line_status_in;
         tx_lvl_q <= tx_level_in;
         rx_lvl_q <= rx_level_in;
      end
   end

   // modem deltas: change sets, read clears, set wins; first cycle only primes
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         msr_delta_q  <= NIB_ZERO;
         msr_prev_q   <= NIB_ZERO;
         msr_primed_q <= 1'b0;
      end else begin
         msr_prev_q   <= modem_in;
         msr_primed_q <= 1'b1;
         msr_delta_q  <= ((rd_hit && bus_addr == OFF_MSR) ? NIB_ZERO : msr_delta_q)
                         | (msr_primed_q ? (modem_in ^ msr_prev_q) : NIB_ZERO);
      end
   end

   // holding registers carry no reset value
   always_ff @(posedge clk_sys) begin
      if (rx_char_valid) begin
         rhr_q <= rx_char;
      end
      if (wr_hit && bus_addr == OFF_DATA) begin
         thr_q <= bus_din;
      end
   end

   // one-cycle load pulse towards the transmitter
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         thr_load_q <= 1'b0;
      end else begin
         thr_load_q <= wr_hit && bus_addr == OFF_DATA;
      end
   end

   // serial and modem pins
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         serial_tx_q <= 1'b1;
         ir_out_q    <= 1'b0;
         rts_n_q     <= 1'b1;
         dtr_n_q     <= 1'b1;
      end else begin
         serial_tx_q <= tx_serial_in && !lcr_q[LCR_BREAK]; // break holds line low
         ir_out_q    <= ir_pulse_in && mcr_q[MCR_IR];
         rts_n_q     <= !mcr_q[MCR_RTS];
         dtr_n_q     <= !mcr_q[MCR_DTR];
      end
   end

   // read data selection; write-only and unmapped offsets read zero
   always_comb begin
      case (bus_addr)
         OFF_DATA:     rd_mux = rhr_q;
         OFF_IER:      rd_mux = ier_q;
         OFF_ISR_FCR:  rd_mux = isr_q;
         OFF_LCR:      rd_mux = lcr_q;
         OFF_MCR:      rd_mux = mcr_q;
         OFF_LSR:      rd_mux = lsr_q;
         OFF_MSR:      rd_mux = {modem_in, msr_delta_q};
         OFF_SPR:      rd_mux = spr_q;
         OFF_FEATURE_CONTROL_REG:     rd_mux = feature_control_reg_q;
         OFF_EFR:      rd_mux = efr_q;
         OFF_TXFIFO:   rd_mux = tx_lvl_q;
         OFF_RXFIFO:   rd_mux = rx_lvl_q;
         OFF_DIV_LO:   rd_mux = div_lo_q;
         OFF_DIV_HI:   rd_mux = div_hi_q;
         OFF_DIV_FR:   rd_mux = div_fr_q;
         OFF_FLOWSTAT: rd_mux = flow_bus.status;
         default:      rd_mux = RST_ZERO;
      endcase
   end

   // bus answer registered one cycle after the read strobe
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         dout_q <= RST_ZERO;
         doe_q  <= 1'b0;
      end else begin
         doe_q <= rd_hit;
         if (rd_hit) begin
            dout_q <= rd_mux;
         end
      end
   end

   // flow status events and clears
   assign flow_bus.tx_evt    = tx_ctrl_sent;
   assign flow_bus.tx_resume = tx_ctrl_resume;
   assign flow_bus.rx_evt    = rx_ctrl_seen;
   assign flow_bus.rx_resume = rx_ctrl_resume;
   assign flow_bus.rd_clr    = rd_hit && bus_addr == OFF_FLOWSTAT;
   assign flow_bus.sw_off    = sw_off_q;

   ufc_flow_status u_flow_status (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .fl      (flow_bus.stat)
   );

   // outputs straight from flops
   assign bus_dout          = dout_q;
   assign bus_doe           = doe_q;
   assign serial_tx         = serial_tx_q;
   assign infrared_out      = ir_out_q;
   assign rts_n             = rts_n_q;
   assign dtr_n             = dtr_n_q;
   assign thr_load          = thr_load_q;
   assign thr_data          = thr_q;
   assign divisor_low       = div_lo_q;
   assign divisor_high_byte = div_hi_q;
   assign divisor_fraction  = div_fr_q;
   assign int_enable        = ier_q;
   assign fifo_ctrl         = fcr_q;
   assign line_ctrl         = lcr_q;
   assign feature_ctrl      = feature_control_reg_q;
   assign enhanced_feature  = efr_q;
   assign tx_trigger        = tx_trig_q;
   assign rx_trigger        = rx_trig_q;
   assign resume_char_one   = resume1_q;
   assign resume_char_two   = resume2_q;
   assign pause_char_one    = pause1_q;
   assign pause_char_two    = pause2_q;
   assign sw_flow_off       = sw_off_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_char_write: assert property (
      wr_hit && bus_addr == OFF_PAUSE2 |=> pause2_q == $past(bus_din))
      else $error("pause character two not written");
   a_flow_read_old: assert property (
      rd_hit && bus_addr == OFF_FLOWSTAT |=> doe_q && dout_q == $past(flow_bus.status))
      else $error("flow status read did not return pre-read value");
   a_off_tracks_efr: assert property (
      efr_q[EFR_SWFC_HI:EFR_SWFC_LO] == NIB_ZERO |=> sw_off_q)
      else $error("flow control not seen as disabled");
   a_off_clears_two: assert property (
      efr_q[EFR_SWFC_HI:EFR_SWFC_LO] == NIB_ZERO ##1 1'b1 |=> flow_bus.status == RST_ZERO)
      else $error("status survived flow control disable");
   a_rts_follows: assert property (
      mcr_q[MCR_RTS] |=> !rts_n_q)
      else $error("rts pin did not follow modem control");
   a_wo_reads_zero: assert property (
      rd_hit && bus_addr == OFF_RESUME1 |=> dout_q == RST_ZERO)
      else $error("write-only character register read back");
   a_break_low: assert property (
      lcr_q[LCR_BREAK] |=> !serial_tx_q)
      else $error("serial line not held low in break");

   c_write_chars: cover property (
      wr_hit && bus_addr == OFF_RESUME1 ##2 wr_hit && bus_addr == OFF_RESUME2);
   c_enable_flow: cover property ($fell(sw_off_q));
endmodule // ufc_top

// ==== common/ufc_pkg.sv ====
// package: register map, field positions and reset values of the flow character block
package ufc_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int NIB_W  = 4;

   typedef logic [ADDR_W-1:0] ufc_addr_t;
   typedef logic [DATA_W-1:0] ufc_data_t;
   typedef logic [NIB_W-1:0]  ufc_nib_t;

   // register offsets on the parallel bus (index = byte address)
   localparam ufc_addr_t OFF_DATA     = 5'h00; // receive_holding rd / transmit_holding wr
   localparam ufc_addr_t OFF_IER      = 5'h01;
   localparam ufc_addr_t OFF_ISR_FCR  = 5'h02; // interrupt_source rd / fifo_control wr
   localparam ufc_addr_t OFF_LCR      = 5'h03;
   localparam ufc_addr_t OFF_MCR      = 5'h04;
   localparam ufc_addr_t OFF_LSR      = 5'h05;
   localparam ufc_addr_t OFF_MSR      = 5'h06;
   localparam ufc_addr_t OFF_SPR      = 5'h07;
   localparam ufc_addr_t OFF_FEATURE_CONTROL_REG     = 5'h08;
   localparam ufc_addr_t OFF_EFR      = 5'h09;
   localparam ufc_addr_t OFF_TXFIFO   = 5'h0a; // tx_fifo_level rd / tx_fifo_trigger wr
   localparam ufc_addr_t OFF_RXFIFO   = 5'h0b; // rx_fifo_level rd / rx_fifo_trigger wr
   localparam ufc_addr_t OFF_DIV_LO   = 5'h0c;
   localparam ufc_addr_t OFF_DIV_HI   = 5'h0d;
   localparam ufc_addr_t OFF_DIV_FR   = 5'h0e;
   localparam ufc_addr_t OFF_RESUME1  = 5'h10;
   localparam ufc_addr_t OFF_RESUME2  = 5'h11;
   localparam ufc_addr_t OFF_PAUSE1   = 5'h12;
   localparam ufc_addr_t OFF_PAUSE2   = 5'h13;
   localparam ufc_addr_t OFF_FLOWSTAT = 5'h14;

   // reset values
   localparam ufc_data_t RST_ZERO   = 8'h00;
   localparam ufc_data_t RST_DIV_LO = 8'h01;
   localparam ufc_data_t RST_ISR    = 8'h01;
   localparam ufc_data_t RST_LSR    = 8'h60;
   localparam ufc_data_t RST_SPR    = 8'hff;
   localparam ufc_nib_t  NIB_ZERO   = 4'h0;

   // field positions
   localparam int FS_TX_RESUME = 3;
   localparam int FS_TX_PAUSE  = 2;
   localparam int FS_RX_RESUME = 1;
   localparam int FS_RX_PAUSE  = 0;
   localparam int EFR_SWFC_HI  = 3;
   localparam int EFR_SWFC_LO  = 0;
   localparam int MCR_DTR      = 0;
   localparam int MCR_RTS      = 1;
   localparam int MCR_IR       = 6;
   localparam int LCR_BREAK    = 6;
endpackage

// ==== common/ufc_flow_if.sv ====
// interface: flow control events and status between bus side and status register
`timescale 1ns/1ns
interface ufc_flow_if;
   import ufc_pkg::*;
   logic      tx_evt;
   logic      tx_resume;
   logic      rx_evt;
   logic      rx_resume;
   logic      rd_clr;
   logic      sw_off;
   ufc_data_t status;

   modport ctrl (output tx_evt, output tx_resume, output rx_evt, output rx_resume,
                 output rd_clr, output sw_off, input status);
   modport stat (input tx_evt, input tx_resume, input rx_evt, input rx_resume,
                 input rd_clr, input sw_off, output status);
endinterface

// ==== hw/ufc_flow_status.sv ====
// module: flow character status register with read clear and disable clear
`timescale 1ns/1ns
module ufc_flow_status (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   ufc_flow_if.stat  fl
);
   import ufc_pkg::*;

   ufc_data_t status_q;
   ufc_data_t status_d;

   // next value: read clear first, events override, disable overrides all
   always_comb begin
      status_d = status_q;
      if (fl.rd_clr) begin
         status_d = RST_ZERO;
      end
      if (fl.tx_evt) begin
         status_d[FS_TX_RESUME] = fl.tx_resume;
         status_d[FS_TX_PAUSE]  = !fl.tx_resume;
      end
      if (fl.rx_evt) begin
         status_d[FS_RX_RESUME] = fl.rx_resume;
         status_d[FS_RX_PAUSE]  = !fl.rx_resume;
      end
      status_d[DATA_W-1:NIB_W] = NIB_ZERO;
      if (fl.sw_off) begin
         status_d = RST_ZERO;
      end
   end

   // status storage
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         status_q <= RST_ZERO;
      end else begin
         status_q <= status_d;
      end
   end

   assign fl.status = status_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_off_forces_zero: assert property (fl.sw_off |=> status_q == RST_ZERO)
      else $error("status not zero after flow control disabled");
   a_tx_resume_mark: assert property (
      fl.tx_evt && fl.tx_resume && !fl.sw_off |=> status_q[FS_TX_RESUME] && !status_q[FS_TX_PAUSE])
      else $error("tx resume not recorded");
   a_tx_pause_mark: assert property (
      fl.tx_evt && !fl.tx_resume && !fl.sw_off
      |=> !status_q[FS_TX_RESUME] && status_q[FS_TX_PAUSE])
      else $error("tx pause not recorded");
   a_rx_resume_mark: assert property (
      fl.rx_evt && fl.rx_resume && !fl.sw_off |=> status_q[FS_RX_RESUME] && !status_q[FS_RX_PAUSE])
      else $error("rx resume not recorded");
   a_rx_pause_mark: assert property (
      fl.rx_evt && !fl.rx_resume && !fl.sw_off
      |=> !status_q[FS_RX_RESUME] && status_q[FS_RX_PAUSE])
      else $error("rx pause not recorded");
   a_read_clears: assert property (
      fl.rd_clr && !fl.tx_evt && !fl.rx_evt |=> status_q == RST_ZERO)
      else $error("status not cleared after read");
   a_reserved_zero: assert property (status_q[DATA_W-1:NIB_W] == NIB_ZERO)
      else $error("reserved status bits set");

   c_tx_then_read: cover property (fl.tx_evt ##2 fl.rd_clr ##1 status_q == RST_ZERO);
   c_set_beats_read: cover property (fl.rd_clr && fl.rx_evt && !fl.sw_off);
   c_off_clear: cover property (status_q != RST_ZERO ##1 fl.sw_off);
endmodule // ufc_flow_status

// ==== verification/ufc_host_model.sv ====
// host processor model for the parallel register bus
`timescale 1ns/1ns
module ufc_host_model (
   input  wire logic               clk_sys,
   output logic                    bus_sel,
   output logic                    bus_rd,
   output logic                    bus_wr,
   output ufc_pkg::ufc_addr_t      bus_addr,
   output ufc_pkg::ufc_data_t      bus_din,
   input  wire ufc_pkg::ufc_data_t bus_dout,
   input  wire logic               bus_doe
);
   import ufc_pkg::*;

   // bus idle from time zero
   initial begin
      bus_sel  = 1'b0;
      bus_rd   = 1'b0;
      bus_wr   = 1'b0;
      bus_addr = 5'h00;
      bus_din  = 8'h00;
   end

   // release: released lines flip so stale values never look valid
   task automatic idle();
      bus_sel  = 1'b0;
      bus_rd   = 1'b0;
      bus_wr   = 1'b0;
      bus_addr = ~bus_addr;
      bus_din  = ~bus_din;
   endtask

   // one write, taken at the rising edge after the request
   task automatic wr(input ufc_addr_t a, input ufc_data_t d);
      @(negedge clk_sys);
      bus_sel  = 1'b1;
      bus_wr   = 1'b1;
      bus_addr = a;
      bus_din  = d;
      @(negedge clk_sys);
      idle();
   endtask

   // one read pulse; data taken only while the output enable is up
   task automatic rd(input ufc_addr_t a, output ufc_data_t d);
      @(negedge clk_sys);
      bus_sel  = 1'b1;
      bus_rd   = 1'b1;
      bus_addr = a;
      @(negedge clk_sys);
      d = (bus_doe === 1'b1) ? bus_dout : 8'hxx;
      idle();
   endtask
endmodule // ufc_host_model

// ==== verification/tb_top.sv ====
// self-checking bench for the flow character register bank
`timescale 1ns/1ns
module tb_top;
   import ufc_pkg::*;
   logic      clk_sys, sys_rst, bus_sel, bus_rd, bus_wr, bus_doe, bg_en;
   logic      tx_ctrl_sent, tx_ctrl_resume, rx_ctrl_seen, rx_ctrl_resume, rx_char_valid;
   logic      tx_serial_in, ir_pulse_in, serial_tx, infrared_out, rts_n, dtr_n;
   logic      thr_load, sw_flow_off;
   ufc_addr_t bus_addr;
   ufc_nib_t  modem_in;
   ufc_data_t bus_din, bus_dout, rx_char, line_status_in, int_source_in, tx_level_in;
   ufc_data_t rx_level_in, thr_data, divisor_low, divisor_high_byte, divisor_fraction;
   ufc_data_t int_enable, fifo_ctrl, line_ctrl, feature_ctrl, enhanced_feature;
   ufc_data_t tx_trigger, rx_trigger, resume_char_one, resume_char_two;
   ufc_data_t pause_char_one, pause_char_two, v, e, x, w, cv [4];
   logic [31:0] seed = 32'h17d1;
   int        bad_count = 0;
   int        checks_done = 0;
   int        cyc = 0;
   ufc_addr_t ra [11] = '{OFF_DIV_LO, OFF_DIV_HI, OFF_DIV_FR, OFF_IER, OFF_LCR, OFF_MCR,
                          OFF_SPR, OFF_FEATURE_CONTROL_REG, OFF_EFR, OFF_FLOWSTAT, OFF_MSR};
   ufc_data_t rv [11] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
                          8'h00, 8'ha0};

   ufc_top ufc_top_i (.clk_sys, .sys_rst, .bus_sel, .bus_rd, .bus_wr, .bus_addr, .bus_din,
      .bus_dout, .bus_doe, .tx_ctrl_sent, .tx_ctrl_resume, .rx_ctrl_seen, .rx_ctrl_resume,
      .rx_char_valid, .rx_char, .line_status_in, .int_source_in, .tx_level_in, .rx_level_in,
      .modem_in, .tx_serial_in, .ir_pulse_in, .serial_tx, .infrared_out, .rts_n, .dtr_n,
      .thr_load, .thr_data, .divisor_low, .divisor_high_byte, .divisor_fraction, .int_enable,
      .fifo_ctrl, .line_ctrl, .feature_ctrl, .enhanced_feature, .tx_trigger, .rx_trigger,
      .resume_char_one, .resume_char_two, .pause_char_one, .pause_char_two, .sw_flow_off);
   ufc_host_model ufc_host_model_i (.clk_sys, .bus_sel, .bus_rd, .bus_wr, .bus_addr,
      .bus_din, .bus_dout, .bus_doe);

   // 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // random source from a fixed seed
   function automatic ufc_data_t rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction

   // expected status after one control character event
   function automatic ufc_data_t flow_next(ufc_data_t s, logic tx, logic res);
      if (tx) s[3:2] = res ? 2'b10 : 2'b01;
      else s[1:0] = res ? 2'b10 : 2'b01;
      return s;
   endfunction

   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // one control character event pulse
   task automatic ev(input logic tx, input logic res);
      @(negedge clk_sys);
      tx_ctrl_sent   = tx;
      rx_ctrl_seen   = !tx;
      tx_ctrl_resume = res;
      rx_ctrl_resume = res;
      @(negedge clk_sys);
      tx_ctrl_sent = 1'b0;
      rx_ctrl_seen = 1'b0;
   endtask

   // reset of 21 cycles, pins checked inside after 20, one read at the first edge after release
   task automatic rst_chk(input ufc_addr_t a, input ufc_data_t ex);
      bg_en          = 1'b0;
      line_status_in = 8'h00;
      int_source_in  = 8'h00;
      tx_serial_in   = 1'b0;
      ir_pulse_in    = 1'b1;
      sys_rst        = 1'b1;
      repeat (20) @(negedge clk_sys);
      chk({serial_tx, infrared_out, rts_n, dtr_n, sw_flow_off, thr_load, bus_doe},
          7'b1011100);
      chk({divisor_low, divisor_high_byte, divisor_fraction, int_enable, fifo_ctrl, line_ctrl,
           feature_ctrl, enhanced_feature, tx_trigger, rx_trigger, resume_char_one,
           resume_char_two, pause_char_one, pause_char_two}, {8'h01, 104'h0});
      fork
         begin
            @(negedge clk_sys);
            sys_rst = 1'b0;
         end
         ufc_host_model_i.rd(a, v);
      join
      chk(v, ex);
      bg_en = 1'b1;
      $display("test reset done");
   endtask

   // live inputs wander at random
   always @(negedge clk_sys) begin
      if (bg_en) begin
         line_status_in <= rnd();
         int_source_in  <= rnd();
         tx_level_in    <= rnd();
         rx_level_in    <= rnd();
         rx_char        <= rnd();
         w = rnd();
         rx_char_valid  <= w[0];
         tx_serial_in   <= w[1];
         ir_pulse_in    <= w[2];
      end
   end

   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         summarize();
      end
   end

   initial begin
      {tx_ctrl_sent, tx_ctrl_resume, rx_ctrl_seen, rx_ctrl_resume, rx_char_valid} = 5'h00;
      {rx_char, tx_level_in, rx_level_in} = 24'h0;
      modem_in = 4'ha;
      rst_chk(OFF_LSR, RST_LSR);
      for (int i = 0; i < 11; i++) begin
         ufc_host_model_i.rd(ra[i], v);
         chk(v, rv[i]);
      end
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         cv[i] = rnd();
         ufc_host_model_i.wr(ufc_addr_t'(OFF_RESUME1 + i), cv[i]);
      end
      chk({resume_char_one, resume_char_two, pause_char_one, pause_char_two},
          {cv[0], cv[1], cv[2], cv[3]});
      for (int i = 0; i < 4; i++) begin
         ufc_host_model_i.rd(ufc_addr_t'(OFF_RESUME1 + i), v);
         chk(v, 8'h00);
      end
      $display("test characters done");
      ufc_host_model_i.wr(OFF_EFR, (rnd() & 8'h0f) | 8'h01);
      repeat (2) @(negedge clk_sys);
      chk(sw_flow_off, 1'b0);
      ufc_host_model_i.wr(OFF_FLOWSTAT, 8'hff);
      for (int i = 0; i < 40; i++) begin
         e = 8'h00;
         x = rnd();
         for (int j = 0; j <= int'(x[1:0]); j++) begin
            v = rnd();
            ev(v[0], v[1]);
            e = flow_next(e, v[0], v[1]);
         end
         ufc_host_model_i.rd(OFF_FLOWSTAT, v);
         chk(v, e);
         ufc_host_model_i.rd(OFF_FLOWSTAT, v);
         chk(v, 8'h00);
      end
      // corner: event and status read on the same edge, read sees old value, set wins
      fork
         ev(1'b0, 1'b1);
         ufc_host_model_i.rd(OFF_FLOWSTAT, v);
      join
      chk(v, 8'h00);
      ufc_host_model_i.rd(OFF_FLOWSTAT, v);
      chk(v, 8'h02);
      $display("test flow status done");
      ev(1'b1, 1'b1);
      ufc_host_model_i.wr(OFF_EFR, 8'h00);
      repeat (2) @(negedge clk_sys);
      ev(1'b0, 1'b0);
      ufc_host_model_i.rd(OFF_FLOWSTAT, v);
      chk(v, 8'h00);
      chk(sw_flow_off, 1'b1);
      $display("test flow disable done");
      ufc_host_model_i.wr(OFF_MCR, 8'h43);
      ufc_host_model_i.wr(OFF_LCR, 8'h40);
      ufc_host_model_i.wr(OFF_EFR, 8'h0f);
      repeat (2) @(negedge clk_sys);
      chk({rts_n, dtr_n, serial_tx}, 3'b000);
      ufc_host_model_i.wr(OFF_DATA, cv[1]);
      chk({thr_load, thr_data}, {1'b1, cv[1]});
      modem_in = 4'h5;
      ufc_host_model_i.rd(OFF_MSR, v);
      chk(v, 8'h5f);
      ufc_host_model_i.rd(OFF_MSR, v);
      chk(v, 8'h50);
      $display("test modem pins done");
      rst_chk(OFF_ISR_FCR, RST_ISR);
      summarize();
   end
endmodule // tb_top
